// file: hw/sdr_pkg.sv
// Shared constants, command codes and helpers for both ends of the link.
// Assumes both ends run on one 50 MHz clock and agree on the mode inputs.
package sdr_pkg;
	// ********************************************************
	// Widths and geometry.
	// ********************************************************
	localparam int BANKS = 4;
	localparam int BA_W = 2;
	localparam int A_W = 13;
	localparam int COL_W = 10;
	localparam int DQ_W = 8;
	localparam int AP_BIT = 10;
	localparam int PIPE_D = 3;
	localparam int CNT_W = 5;
	localparam int MEM_CB = 4;
	localparam int MEM_N = BANKS * (2 ** MEM_CB);
	localparam logic [COL_W-1:0] PAGE_LAST = 10'h3FF;

	// ********************************************************
	// Timing, in ns as specified and in whole clocks.
	// ********************************************************
	localparam int CLK_NS = 20;
	localparam int ACTIVATE_TO_COLUMN_DELAY_NS = 20;
	localparam int TRC_NS = 66;
	localparam int CROSS_BANK_ACTIVATE_INTERVAL_NS = 15;
	localparam int TRP_NS = 20;

	// Minimum times round up, and never below one clock.
	function automatic int cyc_up(input int ns);
		int r;
		r = (ns + CLK_NS - 1) / CLK_NS;
		return (r < 1) ? 1 : r;
	endfunction

	localparam logic [CNT_W-1:0] ACTIVATE_TO_COLUMN_DELAY_CYC = CNT_W'(cyc_up(ACTIVATE_TO_COLUMN_DELAY_NS));
	localparam logic [CNT_W-1:0] TRC_CYC = CNT_W'(cyc_up(TRC_NS));
	localparam logic [CNT_W-1:0] CROSS_BANK_ACTIVATE_INTERVAL_CYC = CNT_W'(cyc_up(CROSS_BANK_ACTIVATE_INTERVAL_NS));
	localparam logic [CNT_W-1:0] TRP_CYC = CNT_W'(cyc_up(TRP_NS));
	localparam logic [CNT_W-1:0] MASK_CYC = 5'h03;

	// ********************************************************
	// Mode codes and commands.
	// ********************************************************
	localparam logic [2:0] BL_1 = 3'h0;
	localparam logic [2:0] BL_2 = 3'h1;
	localparam logic [2:0] BL_4 = 3'h2;
	localparam logic [2:0] BL_8 = 3'h3;
	localparam logic [2:0] BL_PAGE = 3'h7;

	typedef enum logic [2:0] {
		SDR_NOP, SDR_ACT, SDR_RD, SDR_WR, SDR_PRE, SDR_BST
	} sdr_cmd_t;

	typedef enum logic [1:0] {OP_RD, OP_WR, OP_STOP} sdr_op_t;

	// Elements in a fixed burst; a full page answers one.
	function automatic logic [CNT_W-1:0] burst_len(input logic [2:0] bl);
		case (bl)
			BL_2: return 5'h02;
			BL_4: return 5'h04;
			BL_8: return 5'h08;
			default: return 5'h01;
		endcase
	endfunction

	// Fixed bursts wrap inside their aligned block; a full page wraps
	// from the last column back to the starting column.
	function automatic logic [COL_W-1:0] next_col(input logic [2:0] bl,
		input logic [COL_W-1:0] start, input logic [COL_W-1:0] col);
		logic [COL_W-1:0] m;
		m = COL_W'(burst_len(bl) - 5'h01);
		if (bl == BL_PAGE)
			return (col == PAGE_LAST) ? start : col + 10'h001;
		return (col & ~m) | ((col + 10'h001) & m);
	endfunction
endpackage

// file: hw/sdr_if.sv
// Pins between the memory controller and the memory device.
// Assumes one shared clock; the data wire is resolved here from enables.
`timescale 1ns/100ps
interface sdr_if (
	input logic clk,
	input logic rst
);
	sdr_pkg::sdr_cmd_t cmd;
	logic [sdr_pkg::BA_W-1:0] ba;
	logic [sdr_pkg::A_W-1:0] addr;
	logic dqm;
	logic [sdr_pkg::DQ_W-1:0] ctl_dq_o;
	logic ctl_dq_oe;
	logic [sdr_pkg::DQ_W-1:0] dev_dq_o;
	logic dev_dq_oe;
	logic [sdr_pkg::DQ_W-1:0] dq;

	// The device wins a clash; an undriven wire reads as zero.
	assign dq = dev_dq_oe ? dev_dq_o : (ctl_dq_oe ? ctl_dq_o : 8'h00);

	modport dev (
		input clk, rst, cmd, ba, addr, dqm, dq,
		output dev_dq_o, dev_dq_oe
	);
	modport ctl (
		input clk, rst, dq,
		output cmd, ba, addr, dqm, ctl_dq_o, ctl_dq_oe
	);
endinterface

// file: hw/sdr_dev.sv
// Memory device end: bank rows, pipelined read bursts, output masking.
// Assumes commands are synchronous to clk and mode inputs are static.
//
// Notes on behaviour
// - Column access needs row opened by ACTIVE.
// - Controller rounds time limits up to clocks.
// - Precharge before new row; respect row cycle.
// - Other bank may activate during access.
// - READ carries column, bank, auto precharge flag.
// - First data CAS latency after READ.
// - Data lines released when burst completes.
// - Full page runs on, wraps to start.
// - READ truncates READ, gapless, CL-1 early.
// - READ accepted every clock, any bank.
// - WRITE may truncate or follow read.
// - Controller leaves idle cycle before WRITE.
// - Mask raised two clocks before truncating WRITE.
// - WRITE forces data lines off; mask checked.
// - Mask low at WRITE, zero input latency.
// - PRECHARGE truncates read, issued CL-1 early.
// - No same-bank command before precharge time.
// - Optimum PRECHARGE equals auto precharge.
// - Burst terminate ends read, CL-1 early.
// - Terminate stops data only; row stays open.
`timescale 1ns/100ps
module sdr_dev (
	sdr_if.dev bus,
	input wire logic [2:0] mode_bl,
	input wire logic [1:0] mode_cl,
	output logic [sdr_pkg::BANKS-1:0] open_banks,
	output logic cmd_err,
	output logic wr_invalid
);
	// ********************************************************
	// State.
	// ********************************************************
	typedef struct packed {
		logic [sdr_pkg::BANKS-1:0] open;
		logic [sdr_pkg::BANKS-1:0][sdr_pkg::A_W-1:0] row;
		logic act;
		logic page;
		logic ap;
		logic [sdr_pkg::BA_W-1:0] bank;
		logic [sdr_pkg::COL_W-1:0] start;
		logic [sdr_pkg::COL_W-1:0] col;
		logic [sdr_pkg::CNT_W-1:0] rem;
		logic [sdr_pkg::PIPE_D-1:0] pv;
		logic [sdr_pkg::PIPE_D-1:0][sdr_pkg::DQ_W-1:0] pd;
		logic dqm1;
		logic err;
		logic wr_bad;
		logic [sdr_pkg::MEM_N-1:0][sdr_pkg::DQ_W-1:0] mem;
	} sdr_dev_st_t;

	sdr_dev_st_t s_q;
	sdr_dev_st_t s_d;
	logic ins_v;
	logic [sdr_pkg::COL_W-1:0] ins_col;
	logic all_pre;
	logic [1:0] slot;
	logic [sdr_pkg::BA_W+sdr_pkg::MEM_CB-1:0] idx;

	// ********************************************************
	// Next state.
	// ********************************************************
	// The read path is a short shift line: a new element enters at
	// slot CL-1 and reaches slot 0, the pin register, CL-1 edges later,
	// so it is valid at the CL-th edge after the READ.
	always_comb begin
		s_d = s_q;
		ins_v = 1'b0;
		ins_col = s_q.col;
		all_pre = bus.addr[sdr_pkg::AP_BIT];
		slot = (mode_cl == 2'h0) ? 2'h0 : mode_cl - 2'h1;
		idx = '0;
		s_d.err = 1'b0;
		s_d.wr_bad = 1'b0;
		for (int i = 0; i < sdr_pkg::PIPE_D - 1; i++) begin
			s_d.pv[i] = s_q.pv[i+1];
			s_d.pd[i] = s_q.pd[i+1];
		end
		s_d.pv[sdr_pkg::PIPE_D-1] = 1'b0;

		// A running burst yields one element per clock until spent.
		if (s_q.act) begin
			if (s_q.rem == '0 && !s_q.page) begin
				s_d.act = 1'b0;
				if (s_q.ap)
					s_d.open[s_q.bank] = 1'b0;
			end else begin
				ins_v = 1'b1;
				s_d.col = sdr_pkg::next_col(mode_bl, s_q.start, s_q.col);
				if (!s_q.page)
					s_d.rem = s_q.rem - 5'h01;
			end
		end

		// A new READ, WRITE, BURST TERMINATE or PRECHARGE of its bank takes over from the running burst.
		case (bus.cmd)
			sdr_pkg::SDR_ACT: begin
				if (s_q.open[bus.ba]) begin
					s_d.err = 1'b1;
				end else begin
					s_d.open[bus.ba] = 1'b1;
					s_d.row[bus.ba] = bus.addr;
				end
			end
			sdr_pkg::SDR_RD: begin
				if (!s_q.open[bus.ba]) begin
					s_d.err = 1'b1;
				end else begin
					// Restarting here gives the gapless follow-on read.
					ins_v = 1'b1;
					ins_col = bus.addr[sdr_pkg::COL_W-1:0];
					s_d.act = 1'b1;
					s_d.page = (mode_bl == sdr_pkg::BL_PAGE);
					s_d.ap = bus.addr[sdr_pkg::AP_BIT] &&
						(mode_bl != sdr_pkg::BL_PAGE);
					s_d.bank = bus.ba;
					s_d.start = ins_col;
					s_d.col = sdr_pkg::next_col(mode_bl, ins_col, ins_col);
					s_d.rem = sdr_pkg::burst_len(mode_bl) - 5'h01;
				end
			end
			sdr_pkg::SDR_WR: begin
				// Mask must have been high on the clock before.
				s_d.wr_bad = (s_q.act || |s_q.pv) && !s_q.dqm1;
				s_d.act = 1'b0;
				ins_v = 1'b0;
			end
			sdr_pkg::SDR_PRE: begin
				if (all_pre)
					s_d.open = '0;
				else
					s_d.open[bus.ba] = 1'b0;
				if (s_q.act && (all_pre || bus.ba == s_q.bank)) begin
					s_d.act = 1'b0;
					ins_v = 1'b0;
				end
			end
			sdr_pkg::SDR_BST: begin
				// The row stays open; only the data stops.
				s_d.act = 1'b0;
				ins_v = 1'b0;
			end
			default: begin
			end
		endcase

		// Fetch the element into its latency slot.
		if (ins_v) begin
			idx = {s_d.bank, ins_col[sdr_pkg::MEM_CB-1:0]};
			s_d.pv[slot] = 1'b1;
			s_d.pd[slot] = s_q.mem[idx];
		end

		// Mask sampled two edges before the data edge blanks it.
		s_d.pv[0] = s_d.pv[0] & ~s_q.dqm1;

		// A write drops every queued element, whatever the mask.
		if (bus.cmd == sdr_pkg::SDR_WR) begin
			s_d.pv = '0;
			// Single-element write; the mask acts with no delay.
			if (!bus.dqm && s_q.open[bus.ba]) begin
				idx = {bus.ba, bus.addr[sdr_pkg::MEM_CB-1:0]};
				s_d.mem[idx] = bus.dq;
			end
		end
		s_d.dqm1 = bus.dqm;
	end

	// ********************************************************
	// Registers and outputs.
	// ********************************************************
	// Reset clears the whole array, which costs area but keeps reads of
	// unwritten columns defined.
	always_ff @(posedge bus.clk or posedge bus.rst) begin
		if (bus.rst)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	// Once the line empties the pins float again.
	assign bus.dev_dq_o = s_q.pd[0];
	assign bus.dev_dq_oe = s_q.pv[0];
	assign open_banks = s_q.open;
	assign cmd_err = s_q.err;
	assign wr_invalid = s_q.wr_bad;
endmodule

// file: hw/sdr_ctl.sv
// Memory controller end: opens rows, times commands, reads and writes.
// Assumes the device shares clk and sees the same mode inputs.
`timescale 1ns/100ps
module sdr_ctl (
	sdr_if.ctl bus,
	input wire logic [2:0] mode_bl,
	input wire logic [1:0] mode_cl,
	input wire logic req_valid,
	input wire sdr_pkg::sdr_op_t req_op,
	input wire logic [sdr_pkg::BA_W-1:0] req_bank,
	input wire logic [sdr_pkg::A_W-1:0] req_row,
	input wire logic [sdr_pkg::COL_W-1:0] req_col,
	input wire logic req_ap,
	input wire logic [sdr_pkg::DQ_W-1:0] req_wdata,
	output logic req_ready,
	output logic [sdr_pkg::DQ_W-1:0] rd_data,
	output logic rd_valid
);
	// ********************************************************
	// State.
	// ********************************************************
	typedef enum {C_IDLE, C_CHK, C_MASK} sdr_cst_t;
	typedef logic [sdr_pkg::BANKS-1:0][sdr_pkg::CNT_W-1:0] sdr_cnt_t;

	typedef struct packed {
		sdr_cst_t st;
		sdr_pkg::sdr_cmd_t cmd;
		logic [sdr_pkg::BA_W-1:0] ba;
		logic [sdr_pkg::A_W-1:0] addr;
		logic dqm;
		logic [sdr_pkg::DQ_W-1:0] wd;
		logic woe;
		logic rdy;
		sdr_pkg::sdr_op_t op;
		logic [sdr_pkg::BA_W-1:0] bank;
		logic [sdr_pkg::A_W-1:0] row_rq;
		logic [sdr_pkg::COL_W-1:0] col_rq;
		logic ap;
		logic [sdr_pkg::DQ_W-1:0] wdata;
		logic [sdr_pkg::BANKS-1:0] open;
		logic [sdr_pkg::BANKS-1:0][sdr_pkg::A_W-1:0] row;
		sdr_cnt_t activate_to_column_delay_w;
		sdr_cnt_t trc_w;
		sdr_cnt_t trp_w;
		logic [sdr_pkg::CNT_W-1:0] rrd_w;
		logic [sdr_pkg::CNT_W-1:0] mask;
		logic bact;
		logic bpage;
		logic bap;
		logic [sdr_pkg::BA_W-1:0] bbank;
		logic [sdr_pkg::CNT_W-1:0] brem;
		logic [sdr_pkg::PIPE_D-1:0] rpv;
		logic dqm1;
		logic [sdr_pkg::DQ_W-1:0] rdat;
		logic rval;
	} sdr_ctl_st_t;

	sdr_ctl_st_t s_q;
	sdr_ctl_st_t s_d;
	logic [sdr_pkg::BA_W-1:0] b;
	logic m_ins;
	logic col_go;
	logic ap_eff;
	logic [1:0] slot;

	// ********************************************************
	// Next state.
	// ********************************************************
	always_comb begin
		s_d = s_q;
		b = s_q.bank;
		m_ins = 1'b0;
		col_go = 1'b0;
		ap_eff = s_q.ap && (mode_bl != sdr_pkg::BL_PAGE);
		slot = (mode_cl == 2'h0) ? 2'h0 : mode_cl - 2'h1;
		s_d.cmd = sdr_pkg::SDR_NOP;
		s_d.woe = 1'b0;
		s_d.dqm = 1'b0;

		// Wait counters hold clocks left; zero means the limit is met.
		for (int i = 0; i < sdr_pkg::BANKS; i++) begin
			if (s_q.activate_to_column_delay_w[i] != '0)
				s_d.activate_to_column_delay_w[i] = s_q.activate_to_column_delay_w[i] - 5'h01;
			if (s_q.trc_w[i] != '0)
				s_d.trc_w[i] = s_q.trc_w[i] - 5'h01;
			if (s_q.trp_w[i] != '0)
				s_d.trp_w[i] = s_q.trp_w[i] - 5'h01;
		end
		if (s_q.rrd_w != '0)
			s_d.rrd_w = s_q.rrd_w - 5'h01;

		// Mirror of the device read line, driven from the pins as they
		// stand, so a valid bit lines up with the data on the wire.
		// Tracking this locally avoids needing a strobe from the memory.
		s_d.rpv = {1'b0, s_q.rpv[sdr_pkg::PIPE_D-1:1]};
		if (s_q.bact) begin
			if (s_q.brem == '0 && !s_q.bpage) begin
				s_d.bact = 1'b0;
			end else begin
				m_ins = 1'b1;
				if (!s_q.bpage)
					s_d.brem = s_q.brem - 5'h01;
			end
		end
		case (s_q.cmd)
			sdr_pkg::SDR_RD: begin
				m_ins = 1'b1;
				s_d.bact = 1'b1;
				s_d.bpage = (mode_bl == sdr_pkg::BL_PAGE);
				s_d.bap = s_q.addr[sdr_pkg::AP_BIT];
				s_d.bbank = s_q.ba;
				s_d.brem = sdr_pkg::burst_len(mode_bl) - 5'h01;
			end
			sdr_pkg::SDR_PRE, sdr_pkg::SDR_BST, sdr_pkg::SDR_WR: begin
				if (s_q.cmd != sdr_pkg::SDR_PRE || s_q.ba == s_q.bbank) begin
					s_d.bact = 1'b0;
					m_ins = 1'b0;
				end
			end
			default: begin
			end
		endcase
		if (m_ins)
			s_d.rpv[slot] = 1'b1;
		s_d.rpv[0] = s_d.rpv[0] & ~s_q.dqm1;
		if (s_q.cmd == sdr_pkg::SDR_WR)
			s_d.rpv = '0;
		s_d.dqm1 = s_q.dqm;
		s_d.rval = s_q.rpv[0];
		s_d.rdat = bus.dq;

		// Scheduler: one command a clock, NOP otherwise.
		case (s_q.st)
			C_IDLE: begin
				s_d.rdy = 1'b1;
				if (s_q.rdy && req_valid) begin
					s_d.op = req_op;
					s_d.bank = req_bank;
					s_d.row_rq = req_row;
					s_d.col_rq = req_col;
					s_d.ap = req_ap;
					s_d.wdata = req_wdata;
					if (req_op == sdr_pkg::OP_STOP) begin
						// Not allowed on a read that precharges itself.
						if (s_q.bact && !s_q.bap) begin
							s_d.cmd = sdr_pkg::SDR_BST;
							s_d.ba = s_q.bbank;
						end
					end else begin
						s_d.rdy = 1'b0;
						s_d.st = C_CHK;
					end
				end
			end
			C_CHK: begin
				if (!s_q.open[b]) begin
					if (s_q.trp_w[b] == '0 && s_q.trc_w[b] == '0 &&
						s_q.rrd_w == '0) begin
						s_d.cmd = sdr_pkg::SDR_ACT;
						s_d.ba = b;
						s_d.addr = s_q.row_rq;
						s_d.open[b] = 1'b1;
						s_d.row[b] = s_q.row_rq;
						s_d.activate_to_column_delay_w[b] = sdr_pkg::ACTIVATE_TO_COLUMN_DELAY_CYC - 5'h01;
						s_d.trc_w[b] = sdr_pkg::TRC_CYC - 5'h01;
						s_d.rrd_w = sdr_pkg::CROSS_BANK_ACTIVATE_INTERVAL_CYC - 5'h01;
					end
				end else if (s_q.row[b] != s_q.row_rq) begin
					// Closing the row also cuts any read running on it.
					s_d.cmd = sdr_pkg::SDR_PRE;
					s_d.ba = b;
					s_d.addr = '0;
					s_d.open[b] = 1'b0;
					s_d.trp_w[b] = sdr_pkg::TRP_CYC - 5'h01;
				end else if (s_q.activate_to_column_delay_w[b] == '0) begin
					if (s_q.op == sdr_pkg::OP_WR && (s_q.bact || |s_q.rpv ||
						s_q.cmd == sdr_pkg::SDR_RD)) begin
						// Three masked clocks also leave a dead cycle.
						s_d.st = C_MASK;
						s_d.dqm = 1'b1;
						s_d.mask = sdr_pkg::MASK_CYC - 5'h01;
					end else begin
						col_go = 1'b1;
					end
				end
			end
			C_MASK: begin
				s_d.dqm = 1'b1;
				if (s_q.mask == '0)
					col_go = 1'b1;
				else
					s_d.mask = s_q.mask - 5'h01;
			end
			default: s_d.st = C_IDLE;
		endcase

		// Column command; the write drops the mask in the same clock.
		if (col_go) begin
			s_d.cmd = (s_q.op == sdr_pkg::OP_WR) ?
				sdr_pkg::SDR_WR : sdr_pkg::SDR_RD;
			s_d.ba = b;
			s_d.addr = {3'h0, s_q.col_rq};
			s_d.addr[sdr_pkg::AP_BIT] = ap_eff;
			s_d.dqm = 1'b0;
			s_d.woe = (s_q.op == sdr_pkg::OP_WR);
			s_d.wd = s_q.wdata;
			s_d.st = C_IDLE;
			s_d.rdy = 1'b1;
			if (ap_eff) begin
				s_d.open[b] = 1'b0;
				s_d.trp_w[b] = sdr_pkg::burst_len(mode_bl) +
					sdr_pkg::TRP_CYC - 5'h01;
			end
		end
	end

	// ********************************************************
	// Registers and outputs.
	// ********************************************************
	always_ff @(posedge bus.clk or posedge bus.rst) begin
		if (bus.rst)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	// All pins come straight from the state register.
	assign bus.cmd = s_q.cmd;
	assign bus.ba = s_q.ba;
	assign bus.addr = s_q.addr;
	assign bus.dqm = s_q.dqm;
	assign bus.ctl_dq_o = s_q.wd;
	assign bus.ctl_dq_oe = s_q.woe;
	assign req_ready = s_q.rdy;
	assign rd_data = s_q.rdat;
	assign rd_valid = s_q.rval;
endmodule

// file: dv/sdr_asserts.sv
// Concurrent checks on the pins between controller and memory device.
// Assumes the bench instantiates it beside the interface joining both ends.
`timescale 1ns/100ps
module sdr_asserts (
	input wire logic clk,
	input wire logic rst,
	input wire sdr_pkg::sdr_cmd_t cmd,
	input wire logic [sdr_pkg::BA_W-1:0] ba,
	input wire logic dqm,
	input wire logic ctl_dq_oe,
	input wire logic dev_dq_oe,
	input wire logic [sdr_pkg::BANKS-1:0] open_banks,
	input wire logic [2:0] mode_bl,
	input wire logic [1:0] mode_cl
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	// ****************************************
	// Helper counters
	// ****************************************
	// Cycles since the last activation of each bank, saturating.
	logic [sdr_pkg::BANKS-1:0][sdr_pkg::CNT_W-1:0] gap_q;
	always_ff @(posedge clk or posedge rst) begin
		for (int i = 0; i < sdr_pkg::BANKS; i++) begin
			if (rst)
				gap_q[i] <= 5'h1F;
			else if (cmd == sdr_pkg::SDR_ACT && ba == i)
				gap_q[i] <= 5'h01;
			else if (gap_q[i] != 5'h1F)
				gap_q[i] <= gap_q[i] + 5'h01;
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	// Row handling on the command pins.
	a_col_open_row: assert property (cmd inside {sdr_pkg::SDR_RD,
		sdr_pkg::SDR_WR} |-> open_banks[ba])
		else $error("column command to a closed bank");
	a_act_idle_bank: assert property (cmd == sdr_pkg::SDR_ACT
		|-> !open_banks[ba]) else $error("activate to an open bank");
	a_act_same_gap: assert property (cmd == sdr_pkg::SDR_ACT
		|-> gap_q[ba] >= sdr_pkg::TRC_CYC)
		else $error("same bank activations too close");
	// Read data timing; the mask of two clocks earlier must be low.
	a_rd_lat_two: assert property ((cmd == sdr_pkg::SDR_RD &&
		mode_cl == 2'h2 && !dqm) |-> ##2 dev_dq_oe)
		else $error("read data late at latency two");
	a_rd_lat_three: assert property ((cmd == sdr_pkg::SDR_RD &&
		mode_cl == 2'h3 && !dqm) ##1 !dqm |-> ##2 dev_dq_oe)
		else $error("read data late at latency three");
	a_dq_release: assert property ((cmd == sdr_pkg::SDR_RD &&
		mode_bl == sdr_pkg::BL_1 && mode_cl == 2'h2)
		##1 cmd != sdr_pkg::SDR_RD |-> ##2 !dev_dq_oe)
		else $error("data lines held after the burst");
	// Turnaround from read to write.
	a_wr_hiz: assert property (cmd == sdr_pkg::SDR_WR
		|=> !dev_dq_oe [*2]) else $error("device drives after write");
	a_wr_unmasked: assert property (cmd == sdr_pkg::SDR_WR
		|-> !dqm && ctl_dq_oe) else $error("write data masked");
	a_no_contend: assert property (!(dev_dq_oe && ctl_dq_oe))
		else $error("both ends drive the data lines");
endmodule

// file: dv/tb_top.sv
// Bench joining controller and device; a second device gets faulty pins.
// Assumes the design package and interface are compiled before it.
`timescale 1ns/100ps
module tb_top;
	logic clk, rst, req_valid, req_ap, req_ready, rd_valid;
	logic cmd_err, wr_invalid, err2, inv2, fault;
	logic [2:0] mode_bl;
	logic [1:0] mode_cl, req_bank;
	sdr_pkg::sdr_op_t req_op;
	logic [12:0] req_row;
	logic [9:0] req_col;
	logic [7:0] req_wdata, rd_data;
	logic [3:0] open_banks, open2;
	logic [7:0] mem [64];
	logic [7:0] got_q [$], exp_q [$];
	int t_q [$];
	int err_total, n_tests, cyc;

	sdr_if bus (.clk(clk), .rst(rst));
	sdr_if bus2 (.clk(clk), .rst(rst));
	sdr_ctl sdr_ctl_inst (.bus(bus), .mode_bl(mode_bl), .mode_cl(mode_cl),
		.req_valid(req_valid), .req_op(req_op), .req_bank(req_bank),
		.req_row(req_row), .req_col(req_col), .req_ap(req_ap),
		.req_wdata(req_wdata), .req_ready(req_ready),
		.rd_data(rd_data), .rd_valid(rd_valid));
	sdr_dev sdr_dev_inst (.bus(bus), .mode_bl(mode_bl), .mode_cl(mode_cl),
		.open_banks(open_banks), .cmd_err(cmd_err), .wr_invalid(wr_invalid));
	sdr_dev sdr_dev_inst2 (.bus(bus2), .mode_bl(mode_bl), .mode_cl(mode_cl),
		.open_banks(open2), .cmd_err(err2), .wr_invalid(inv2));
	sdr_asserts sdr_asserts_inst (.clk(clk), .rst(rst), .cmd(bus.cmd),
		.ba(bus.ba), .dqm(bus.dqm), .ctl_dq_oe(bus.ctl_dq_oe),
		.dev_dq_oe(bus.dev_dq_oe), .open_banks(open_banks),
		.mode_bl(mode_bl), .mode_cl(mode_cl));

	// Free running 50 MHz clock.
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// Collects read elements with their cycle, and cuts a hang short.
	always @(posedge clk) begin
		cyc++;
		if (rd_valid === 1'b1) begin
			got_q.push_back(rd_data);
			t_q.push_back(cyc);
		end
		if (cmd_err !== 1'b0 || wr_invalid !== 1'b0)
			fault = !rst;
		if (cyc == 20000) begin
			err_total++;
			final_report();
		end
	end

	task automatic chk(input string what, input logic [7:0] exp, got);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic final_report();
		$display("comparisons %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// One user request, held until the controller takes it.
	task automatic req(input sdr_pkg::sdr_op_t op, input logic [1:0] b,
		input logic [9:0] c, input logic ap, input logic [7:0] wd);
		int k;
		@(negedge clk);
		req_valid = 1'b1;
		req_op = op;
		req_bank = b;
		req_col = c;
		req_ap = ap;
		req_wdata = wd;
		k = 0;
		while (req_ready !== 1'b1 && k < 60) begin
			@(negedge clk);
			k++;
		end
		@(negedge clk);
		req_valid = 1'b0;
		if (op == sdr_pkg::OP_WR)
			mem[{b, c[3:0]}] = wd;
	endtask

	task automatic wait_n(input int n);
		int k;
		k = 0;
		while (got_q.size() < n && k < 300) begin
			@(negedge clk);
			k++;
		end
	endtask

	// Fixed bursts wrap inside their aligned block.
	task automatic expect_burst(input logic [1:0] b, input logic [9:0] c,
		input int len);
		for (int k = 0; k < len; k++)
			exp_q.push_back(mem[{b, 4'((c & ~(len - 1)) | ((c + k) & (len - 1)))}]);
	endtask

	// Elements, values and a gapless span, then clears the queues.
	task automatic compare_all();
		wait_n(exp_q.size());
		repeat (12) @(negedge clk);
		chk("element count", 8'(exp_q.size()), 8'(got_q.size()));
		for (int k = 0; k < exp_q.size(); k++)
			chk("read data", exp_q[k], got_q[k]);
		if (t_q.size() > 0)
			chk("span", 8'(exp_q.size() - 1), 8'(t_q[$] - t_q[0]));
		exp_q.delete();
		got_q.delete();
		t_q.delete();
	endtask

	// Faulty pins for the second device.
	task automatic cmd2(input sdr_pkg::sdr_cmd_t c, input logic [1:0] b);
		@(negedge clk);
		bus2.cmd = c;
		bus2.ba = b;
	endtask

	initial begin
		{req_valid, req_ap, fault, req_bank, req_col, req_wdata} = '0;
		{bus2.addr, bus2.dqm, bus2.ctl_dq_o, bus2.ctl_dq_oe} = '0;
		bus2.cmd = sdr_pkg::SDR_NOP;
		bus2.ba = 2'h0;
		req_op = sdr_pkg::OP_RD;
		req_row = 13'h0055;
		mode_bl = sdr_pkg::BL_1;
		mode_cl = 2'h2;
		foreach (mem[i])
			mem[i] = 8'h00;
		rst = 1'b1;
		repeat (2) @(posedge clk);
		@(negedge clk);
		rst = 1'b0;
		chk("open rows", 8'h00, 8'(open_banks));
		for (int i = 0; i < 16; i++)
			req(sdr_pkg::OP_WR, 2'h0, 10'(i), 1'b0, 8'h40 + 8'(i));
		req(sdr_pkg::OP_WR, 2'h2, 10'h3FE, 1'b0, 8'hE5);
		req(sdr_pkg::OP_WR, 2'h2, 10'h3FF, 1'b0, 8'hF5);
		got_q.delete();
		t_q.delete();
		// Every latency against every fixed burst length.
		for (int l = 1; l < 4; l++) begin
			for (int j = 0; j < 4; j++) begin
				mode_cl = 2'(l);
				mode_bl = 3'(j);
				req(sdr_pkg::OP_RD, 2'h0, 10'h005, 1'b0, 8'h00);
				expect_burst(2'h0, 10'h005, 1 << j);
				compare_all();
			end
		end
		// Back-to-back reads to two banks keep the data flowing.
		mode_bl = sdr_pkg::BL_4;
		req(sdr_pkg::OP_RD, 2'h0, 10'h002, 1'b0, 8'h00);
		req(sdr_pkg::OP_RD, 2'h2, 10'h3FE, 1'b0, 8'h00);
		// The second read lands two clocks after the first and cuts it
		// after two elements, so only those two come out of bank 0.
		expect_burst(2'h0, 10'h002, 2);
		expect_burst(2'h2, 10'h3FE, 4);
		compare_all();
		// Auto precharge closes the row; a plain read reopens it.
		mode_bl = sdr_pkg::BL_2;
		mode_cl = 2'h2;
		req(sdr_pkg::OP_RD, 2'h0, 10'h000, 1'b1, 8'h00);
		expect_burst(2'h0, 10'h000, 2);
		compare_all();
		chk("row after auto close", 8'h00, 8'(open_banks[0]));
		req(sdr_pkg::OP_RD, 2'h0, 10'h001, 1'b0, 8'h00);
		expect_burst(2'h0, 10'h001, 2);
		compare_all();
		chk("row kept open", 8'h01, 8'(open_banks[0]));
		// Full page wraps to the start column until stopped.
		mode_bl = sdr_pkg::BL_PAGE;
		req(sdr_pkg::OP_RD, 2'h2, 10'h3FE, 1'b0, 8'h00);
		wait_n(6);
		req(sdr_pkg::OP_STOP, 2'h2, 10'h000, 1'b0, 8'h00);
		repeat (20) @(negedge clk);
		for (int k = 0; k < 6; k++)
			chk("page data", k[0] ? 8'hF5 : 8'hE5, got_q[k]);
		exp_q.push_back(8'(got_q.size()));
		repeat (20) @(negedge clk);
		chk("page stopped", exp_q[0], 8'(got_q.size()));
		chk("row after stop", 8'h01, 8'(open_banks[2]));
		exp_q.delete();
		got_q.delete();
		t_q.delete();
		// A new row in an open bank costs a precharge and an activate.
		mode_bl = sdr_pkg::BL_2;
		req_row = 13'h0066;
		req(sdr_pkg::OP_RD, 2'h2, 10'h3FE, 1'b0, 8'h00);
		chk("ready while busy", 8'h00, 8'(req_ready));
		expect_burst(2'h2, 10'h3FE, 2);
		compare_all();
		chk("row after reopen", 8'h01, 8'(open_banks[2]));
		// A write cuts a long read; its data must land unmasked.
		mode_bl = sdr_pkg::BL_8;
		mode_cl = 2'h3;
		req(sdr_pkg::OP_RD, 2'h0, 10'h000, 1'b0, 8'h00);
		req(sdr_pkg::OP_WR, 2'h0, 10'h003, 1'b0, 8'h77);
		repeat (20) @(negedge clk);
		got_q.delete();
		t_q.delete();
		mode_bl = sdr_pkg::BL_1;
		req(sdr_pkg::OP_RD, 2'h0, 10'h003, 1'b0, 8'h00);
		expect_burst(2'h0, 10'h003, 1);
		compare_all();
		chk("device fault flags", 8'h00, 8'(fault));
		// Second device: closed bank read, open bank activate, bad write.
		mode_bl = sdr_pkg::BL_8;
		mode_cl = 2'h2;
		cmd2(sdr_pkg::SDR_RD, 2'h1);
		cmd2(sdr_pkg::SDR_NOP, 2'h1);
		chk("closed bank read", 8'h01, 8'(err2));
		cmd2(sdr_pkg::SDR_ACT, 2'h1);
		cmd2(sdr_pkg::SDR_ACT, 2'h1);
		cmd2(sdr_pkg::SDR_RD, 2'h1);
		chk("open bank activate", 8'h01, 8'(err2));
		cmd2(sdr_pkg::SDR_NOP, 2'h1);
		cmd2(sdr_pkg::SDR_WR, 2'h1);
		cmd2(sdr_pkg::SDR_NOP, 2'h1);
		chk("unmasked write", 8'h01, 8'(inv2));
		chk("lines after write", 8'h00, 8'(bus2.dev_dq_oe));
		final_report();
	end
endmodule
